//--- rx_event_encoder.sv
// Receive event encoder: turns unit reports into 32-bit queue entries.
// Assumes sources hold a report until accepted and the queue unit
// takes one word per cycle when ready.
`timescale 1ns/1ps
`include "rx_event_params.svh"
// Functional notes
// - Each entry is one 32-bit type-plus-info word
// - Info is cleared-low pointer, descriptor or data
// - Good AAL5 packet posts 000000 with pointer
// - Good FIFO-mode AAL5 packet posts 001110
// - Header threshold exceeded posts 000001 header pointer
// - Bad CRC posts 000010, bad-frame pointer choice
// - Bad CRC good length posts 001111
// - Bad length posts 000011, bad-frame choice
// - Over maximum length posts 000100
// - Reassembly timeout posts 000101, bad-frame choice
// - Forward abort 000110; nonzero CPI 000111
// - AAL0 user cell posts 001000 cell pointer
// - Non-user cell 001001 good, 001010 bad CRC
// - Bad HEC, range, zero index post cell pointer
// - Pool exhaustion drops cell, posts descriptor error
// - FIFO drop, threshold, full, timeout events
// - Counter overflows route to count class
// - Thresholds and transmit events route tx-complete
// - DMA completions carry descriptor, split tx/rx
// - Zero address both DMA; cancel rx DMA
// - Resource errors are error class, bad-frame choice
// - ABR events go to configured queue
// - Threshold direction in info bit six
module rx_event_encoder
  import rx_event_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input rx_event_pkg::pkt_evt_type pkt_evt_in,      // Reassembly report
  input wire logic bad_frame_en_in,                 // Channel receives bad frames
  input rx_event_pkg::cell_evt_type cell_evt_in,    // Cell report
  input rx_event_pkg::raw_evt_type raw_evt_in,      // Transmit, DMA, ABR, pool, user
  input wire logic thresh_up_in,                    // Threshold crossing direction
  input wire logic [2:0] abr_queue_in,              // ABR routing setting
  input wire logic [2:0] class_queue_in,            // Queue for non-ABR events
  input wire logic queue_ready_in,                  // Queue unit takes a word
  output logic pkt_ack_out,                         // Report taken, one pulse
  output logic cell_ack_out,
  output logic raw_ack_out,
  output rx_event_pkg::evt_out_type evt_out         // Finished entry
);
  import rx_event_pkg::*;

  // Whole state of the block
  typedef struct packed {
    evt_out_type evt;
    logic pkt_ack;
    logic cell_ack;
    logic raw_ack;
  } state_type;

  state_type state;       // Registered state
  state_type next_state;  // Combinational copy

  // Clear the low pointer bits so they never carry stray flags
  function automatic logic [`EVT_INFO_W-1:0] ptr_clean(input logic [`EVT_INFO_W-1:0] p);
    ptr_clean = {p[`EVT_INFO_W-1:`EVT_PTR_LOW_ZERO], {`EVT_PTR_LOW_ZERO{1'b0}}};
  endfunction

  // Routing class from the type code alone
  function automatic route_type classify(input logic [`EVT_TYPE_W-1:0] c);
    route_type r;
    r = '0;
    case (c)
      `EVT_AAL5_BAD_CRC, `EVT_AAL5_BAD_LEN, `EVT_AAL5_MAX_LEN, `EVT_AAL5_TIMEOUT,
      `EVT_AAL5_ABORT, `EVT_AAL5_CPI, `EVT_AAL5_CRC_GOOD_LEN, `EVT_NUD_BAD_CRC,
      `EVT_CELL_BAD_HEC, `EVT_CELL_RANGE, `EVT_CELL_ZERO_IDX, `EVT_DROP_AAL0,
      `EVT_DROP_AAL5, `EVT_DROP_NUD, `EVT_FIFO_DROP, `EVT_FIFO_TIMEOUT,
      `EVT_VMEM, `EVT_BUF_OVF, `EVT_NO_CT_DESC, `EVT_NO_SCATTER: begin
        r.error = 1'b1;
      end
      `EVT_ENTITY_CNT: begin
        r.count = 1'b1;
      end
      `EVT_TXDMA_DONE, `EVT_TXDMA_ERR, `EVT_TXDMA_VERR: begin
        r.tx_dma = 1'b1;
      end
      `EVT_RXDMA_DONE, `EVT_RXDMA_ERR, `EVT_CT_CANCEL: begin
        r.rx_dma = 1'b1;
      end
      `EVT_DMA_ZERO: begin
        r.tx_dma = 1'b1;
        r.rx_dma = 1'b1;
      end
      `EVT_POOL_STATUS: begin
        r.pool = 1'b1;
      end
      default: begin
        // Ranges: counters, tx-complete, ABR; user codes get nothing
        if (c[5:2] == 4'(`EVT_CNT_BASE >> 2)) begin
          r.count = 1'b1;
        end else if (c >= `EVT_THRESH1 && c <= `EVT_TX_CLOSED) begin
          r.tx_comp = 1'b1;
        end else if (c >= `EVT_ABR_FIRST && c <= `EVT_ABR_LAST) begin
          r.abr = 1'b1;
        end
      end
    endcase
    classify = r;
  endfunction

  // Reassembly outcome to code and pointer choice
  logic [`EVT_TYPE_W-1:0] pkt_code;
  logic pkt_use_bad_frame;  // Pointer follows the bad-frame setting
  always_comb begin
    pkt_use_bad_frame = 1'b1;
    case (pkt_evt_in.kind)
      pkt_good: begin
        pkt_code = `EVT_AAL5_GOOD;
        pkt_use_bad_frame = 1'b0;
      end
      pkt_fifo_good: begin
        pkt_code = `EVT_AAL5_FIFO_GOOD;
        pkt_use_bad_frame = 1'b0;
      end
      pkt_header: begin
        pkt_code = `EVT_AAL5_HDR;
        pkt_use_bad_frame = 1'b0;
      end
      pkt_bad_crc: pkt_code = `EVT_AAL5_BAD_CRC;
      pkt_crc_good_len: pkt_code = `EVT_AAL5_CRC_GOOD_LEN;
      pkt_bad_len: pkt_code = `EVT_AAL5_BAD_LEN;
      pkt_max_len: pkt_code = `EVT_AAL5_MAX_LEN;
      pkt_timeout: pkt_code = `EVT_AAL5_TIMEOUT;
      pkt_abort: pkt_code = `EVT_AAL5_ABORT;
      pkt_cpi: pkt_code = `EVT_AAL5_CPI;
      pkt_vmem: pkt_code = `EVT_VMEM;
      pkt_buf_ovf: pkt_code = `EVT_BUF_OVF;
      pkt_no_ct_desc: pkt_code = `EVT_NO_CT_DESC;
      pkt_no_scatter: pkt_code = `EVT_NO_SCATTER;
      default: pkt_code = `EVT_AAL5_BAD_CRC;
    endcase
  end

  // Cell outcome to code and pointer choice
  logic [`EVT_TYPE_W-1:0] cell_code;
  logic [1:0] cell_ptr_sel;  // 0 cell, 1 descriptor, 2 bad-frame choice
  always_comb begin
    cell_ptr_sel = 2'h0;
    case (cell_evt_in.kind)
      cell_user: cell_code = `EVT_CELL_USER;
      cell_nud: cell_code = `EVT_NUD_GOOD;
      cell_nud_bad: begin
        cell_code = `EVT_NUD_BAD_CRC;
        cell_ptr_sel = 2'h2;
      end
      cell_hec: cell_code = `EVT_CELL_BAD_HEC;
      cell_range: cell_code = `EVT_CELL_RANGE;
      cell_zero_idx: cell_code = `EVT_CELL_ZERO_IDX;
      cell_drop_aal0: begin
        cell_code = `EVT_DROP_AAL0;
        cell_ptr_sel = 2'h1;
      end
      cell_drop_aal5: begin
        cell_code = `EVT_DROP_AAL5;
        cell_ptr_sel = 2'h1;
      end
      cell_drop_nud: begin
        cell_code = `EVT_DROP_NUD;
        cell_ptr_sel = 2'h1;
      end
      fifo_drop: begin
        cell_code = `EVT_FIFO_DROP;
        cell_ptr_sel = 2'h1;
      end
      fifo_thresh: begin
        cell_code = `EVT_FIFO_THRESH;
        cell_ptr_sel = 2'h1;
      end
      fifo_full: begin
        cell_code = `EVT_FIFO_FULL;
        cell_ptr_sel = 2'h1;
      end
      fifo_timeout: begin
        cell_code = `EVT_FIFO_TIMEOUT;
        cell_ptr_sel = 2'h1;
      end
      default: begin
        cell_code = `EVT_CELL_USER;
        cell_ptr_sel = 2'h0;
      end
    endcase
  end

  // Output stage is free when empty or being drained this cycle
  logic out_free;
  assign out_free = !state.evt.valid || queue_ready_in;

  // Next state: one source per cycle, packets first, then cells, then the rest
  always_comb begin
    logic [`EVT_TYPE_W-1:0] code;
    logic [`EVT_INFO_W-1:0] info;
    code = '0;
    info = '0;
    next_state = state;
    next_state.pkt_ack = 1'b0;
    next_state.cell_ack = 1'b0;
    next_state.raw_ack = 1'b0;
    if (queue_ready_in) begin
      next_state.evt.valid = 1'b0;
    end
    // Acks pulse for one cycle, so a held report is not taken twice
    if (out_free && pkt_evt_in.valid && !state.pkt_ack) begin
      code = pkt_code;
      // Bad frames kept: packet pointer, else the channel descriptor
      info = (!pkt_use_bad_frame || bad_frame_en_in) ? ptr_clean(pkt_evt_in.pkt_ptr)
                                                     : ptr_clean(pkt_evt_in.lcd_ptr);
      next_state.pkt_ack = 1'b1;
      next_state.evt.valid = 1'b1;
    end else if (out_free && cell_evt_in.valid && !state.cell_ack) begin
      code = cell_code;
      if (cell_ptr_sel == 2'h1 || (cell_ptr_sel == 2'h2 && !bad_frame_en_in)) begin
        info = ptr_clean(cell_evt_in.lcd_ptr);
      end else begin
        info = ptr_clean(cell_evt_in.cell_ptr);
      end
      next_state.cell_ack = 1'b1;
      next_state.evt.valid = 1'b1;
    end else if (out_free && raw_evt_in.valid && !state.raw_ack) begin
      code = raw_evt_in.code;
      info = raw_evt_in.info;
      if (code == `EVT_THRESH1 || code == `EVT_THRESH2) begin
        info[`EVT_DIR_BIT] = thresh_up_in;
      end
      next_state.raw_ack = 1'b1;
      next_state.evt.valid = 1'b1;
    end
    if (next_state.pkt_ack || next_state.cell_ack || next_state.raw_ack) begin
      next_state.evt.word = {code, info};
      next_state.evt.route = classify(code);
      next_state.evt.queue = (code >= `EVT_ABR_FIRST && code <= `EVT_ABR_LAST)
                             ? abr_queue_in : class_queue_in;
    end
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pkt_ack_out = state.pkt_ack;
  assign cell_ack_out = state.cell_ack;
  assign raw_ack_out = state.raw_ack;
  assign evt_out = state.evt;

  // Which source each edge takes, in the same priority as above, for the checks
  logic pkt_take;
  logic cell_take;
  logic raw_take;
  assign pkt_take = out_free && pkt_evt_in.valid && !state.pkt_ack;
  assign cell_take = out_free && cell_evt_in.valid && !state.cell_ack && !pkt_take;
  assign raw_take = out_free && raw_evt_in.valid && !state.raw_ack && !pkt_take && !cell_take;

  // Good packet yields type 0 one cycle later
  chk_good_pkt_code: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (pkt_take && pkt_evt_in.kind == pkt_good)
    |=> evt_out.valid && evt_out.word[31:26] == 6'h00) else $error("good packet code wrong");
  chk_fifo_pkt_code: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (pkt_take && pkt_evt_in.kind == pkt_fifo_good)
    |=> evt_out.word[31:26] == 6'h0e) else $error("fifo packet code wrong");
  // Header threshold event always points at the packet
  chk_header_ptr: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (pkt_take && pkt_evt_in.kind == pkt_header) |=> evt_out.word[31:26] == 6'h01
    && evt_out.word[25:6] == $past(pkt_evt_in.pkt_ptr[25:6])) else $error("header event wrong");
  chk_bad_crc_ptr: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (pkt_take && pkt_evt_in.kind == pkt_bad_crc && !bad_frame_en_in)
    |=> evt_out.word[25:6] == $past(pkt_evt_in.lcd_ptr[25:6])) else $error("bad crc pointer wrong");
  chk_crc_len_code: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (pkt_take && pkt_evt_in.kind == pkt_crc_good_len)
    |=> evt_out.word[31:26] == 6'h0f && evt_out.route.error) else $error("crc good length code wrong");
  // Bad frames kept: the packet pointer replaces the descriptor
  chk_bad_len_ptr: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (pkt_take && pkt_evt_in.kind == pkt_bad_len && bad_frame_en_in) |=> evt_out.word[31:26] == 6'h03
    && evt_out.word[25:6] == $past(pkt_evt_in.pkt_ptr[25:6])) else $error("bad length event wrong");
  chk_max_len_code: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (pkt_take && pkt_evt_in.kind == pkt_max_len)
    |=> evt_out.word[31:26] == 6'h04 && evt_out.route.error) else $error("max length code wrong");
  chk_timeout_code: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (pkt_take && pkt_evt_in.kind == pkt_timeout && !bad_frame_en_in) |=> evt_out.word[31:26] == 6'h05
    && evt_out.word[25:6] == $past(pkt_evt_in.lcd_ptr[25:6])) else $error("timeout event wrong");
  chk_cpi_code: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (pkt_take && pkt_evt_in.kind == pkt_cpi)
    |=> evt_out.word[31:26] == 6'h07 && evt_out.route.error) else $error("cpi code wrong");
  chk_ptr_low_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(pkt_ack_out) |-> evt_out.word[5:0] == 6'h00) else $error("pointer low bits set");
  // Cells lose to packets, so the taken flag already folds that in
  chk_user_cell_ptr: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (cell_take && cell_evt_in.kind == cell_user)
    |=> evt_out.word == {6'h08, $past(cell_evt_in.cell_ptr[25:6]), 6'h00})
    else $error("user cell event wrong");
  chk_nud_bad_ptr: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (cell_take && cell_evt_in.kind == cell_nud_bad && !bad_frame_en_in) |=> evt_out.word[31:26] == 6'h0a
    && evt_out.word[25:6] == $past(cell_evt_in.lcd_ptr[25:6])) else $error("bad crc10 event wrong");
  chk_bad_hec_code: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (cell_take && cell_evt_in.kind == cell_hec)
    |=> evt_out.word[31:26] == 6'h0b && evt_out.route.error) else $error("bad hec code wrong");
  chk_drop_error: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (evt_out.valid && evt_out.word[31:26] >= 6'h10 && evt_out.word[31:26] <= 6'h12)
    |-> evt_out.route.error) else $error("drop not error class");
  // FIFO threshold is informational: descriptor pointer, no class
  chk_fifo_thresh: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (cell_take && cell_evt_in.kind == fifo_thresh) |=> evt_out.word[31:26] == 6'h14 && evt_out.route == '0
    && evt_out.word[25:6] == $past(cell_evt_in.lcd_ptr[25:6])) else $error("fifo threshold event wrong");
  chk_count_class: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (evt_out.valid && (evt_out.word[31:26] == 6'h3d || evt_out.word[31:28] == 4'h6))
    |-> evt_out.route.count) else $error("counter overflow not count class");
  chk_tx_comp_class: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (evt_out.valid && evt_out.word[31:26] >= 6'h1e && evt_out.word[31:26] <= 6'h23)
    |-> evt_out.route.tx_comp) else $error("transmit event not tx complete class");
  chk_tx_dma_class: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (evt_out.valid && evt_out.word[31:26] inside {6'h24, 6'h26, 6'h28})
    |-> evt_out.route.tx_dma && !evt_out.route.rx_dma) else $error("transmit dma class wrong");
  // DMA events carry the descriptor address untouched
  chk_raw_info_pass: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (raw_take && raw_evt_in.code == 6'h24)
    |=> evt_out.word[25:0] == $past(raw_evt_in.info)) else $error("dma info altered");
  chk_zero_addr_dma: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (evt_out.valid && evt_out.word[31:26] == 6'h29) |-> evt_out.route.tx_dma && evt_out.route.rx_dma)
    else $error("zero address not both dma");
  chk_resource_error: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (evt_out.valid && evt_out.word[31:26] inside {6'h38, 6'h39, 6'h3a, 6'h3c})
    |-> evt_out.route.error) else $error("resource event not error class");
  chk_abr_queue: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (raw_take && raw_evt_in.code == 6'h2d) |=> evt_out.queue == $past(abr_queue_in))
    else $error("abr queue wrong");
  chk_user_no_class: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (evt_out.valid && evt_out.word[31:29] == 3'h6) |-> evt_out.route == '0)
    else $error("user event routed");
  chk_thresh_dir: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (raw_take && raw_evt_in.code == 6'h1e) |=> evt_out.word[6] == $past(thresh_up_in) && evt_out.route.tx_comp)
    else $error("threshold direction wrong");
endmodule

//--- rx_event_params.svh
// Constants for the receive event encoder: field layout and event type codes.
// Assumes inclusion by the package and the design module only.
`ifndef RX_EVENT_PARAMS_SVH
`define RX_EVENT_PARAMS_SVH
`define EVT_WORD_W 32
`define EVT_TYPE_W 6
`define EVT_TYPE_LSB 26
`define EVT_INFO_W 26
`define EVT_PTR_LOW_ZERO 6
`define EVT_DIR_BIT 6
`define EVT_AAL5_GOOD 6'h00
`define EVT_AAL5_HDR 6'h01
`define EVT_AAL5_BAD_CRC 6'h02
`define EVT_AAL5_BAD_LEN 6'h03
`define EVT_AAL5_MAX_LEN 6'h04
`define EVT_AAL5_TIMEOUT 6'h05
`define EVT_AAL5_ABORT 6'h06
`define EVT_AAL5_CPI 6'h07
`define EVT_CELL_USER 6'h08
`define EVT_NUD_GOOD 6'h09
`define EVT_NUD_BAD_CRC 6'h0a
`define EVT_CELL_BAD_HEC 6'h0b
`define EVT_CELL_RANGE 6'h0c
`define EVT_CELL_ZERO_IDX 6'h0d
`define EVT_AAL5_FIFO_GOOD 6'h0e
`define EVT_AAL5_CRC_GOOD_LEN 6'h0f
`define EVT_DROP_AAL0 6'h10
`define EVT_DROP_AAL5 6'h11
`define EVT_DROP_NUD 6'h12
`define EVT_FIFO_DROP 6'h13
`define EVT_FIFO_THRESH 6'h14
`define EVT_FIFO_FULL 6'h15
`define EVT_FIFO_TIMEOUT 6'h16
`define EVT_CNT_BASE 6'h18
`define EVT_THRESH1 6'h1e
`define EVT_THRESH2 6'h1f
`define EVT_TX_DONE 6'h20
`define EVT_TX_CLOSED 6'h23
`define EVT_TXDMA_DONE 6'h24
`define EVT_RXDMA_DONE 6'h25
`define EVT_TXDMA_ERR 6'h26
`define EVT_RXDMA_ERR 6'h27
`define EVT_TXDMA_VERR 6'h28
`define EVT_DMA_ZERO 6'h29
`define EVT_ABR_FIRST 6'h2c
`define EVT_ABR_LAST 6'h2f
`define EVT_USER_FIRST 6'h30
`define EVT_USER_LAST 6'h37
`define EVT_VMEM 6'h38
`define EVT_BUF_OVF 6'h39
`define EVT_NO_CT_DESC 6'h3a
`define EVT_CT_CANCEL 6'h3b
`define EVT_NO_SCATTER 6'h3c
`define EVT_ENTITY_CNT 6'h3d
`define EVT_POOL_STATUS 6'h3e
`define EVT_TIMESTAMP 6'h3f
`endif

//--- rx_event_pkg.sv
// Types shared by the receive event encoder and its users.
// Assumes the constants header sits in the same folder.
`include "rx_event_params.svh"
package rx_event_pkg;
  // Source of a reassembly outcome
  typedef enum logic [3:0] {
    pkt_good = 4'h0, pkt_fifo_good = 4'h1, pkt_bad_crc = 4'h2, pkt_crc_good_len = 4'h3,
    pkt_bad_len = 4'h4, pkt_max_len = 4'h5, pkt_timeout = 4'h6, pkt_abort = 4'h7,
    pkt_cpi = 4'h8, pkt_vmem = 4'h9, pkt_buf_ovf = 4'ha, pkt_no_ct_desc = 4'hb,
    pkt_no_scatter = 4'hc, pkt_header = 4'hd
  } pkt_kind_type;
  // Cell outcome
  typedef enum logic [3:0] {
    cell_user = 4'h0, cell_nud = 4'h1, cell_nud_bad = 4'h2, cell_hec = 4'h3,
    cell_range = 4'h4, cell_zero_idx = 4'h5, cell_drop_aal0 = 4'h6, cell_drop_aal5 = 4'h7,
    cell_drop_nud = 4'h8, fifo_drop = 4'h9, fifo_thresh = 4'ha, fifo_full = 4'hb,
    fifo_timeout = 4'hc
  } cell_kind_type;
  // Generic report: source supplies the type code itself
  typedef struct packed {
    logic valid;
    logic [`EVT_TYPE_W-1:0] code;
    logic [`EVT_INFO_W-1:0] info;
  } raw_evt_type;
  // Reassembly report with both pointers so the encoder can pick one
  typedef struct packed {
    logic valid;
    pkt_kind_type kind;
    logic [`EVT_INFO_W-1:0] pkt_ptr;
    logic [`EVT_INFO_W-1:0] lcd_ptr;
  } pkt_evt_type;
  typedef struct packed {
    logic valid;
    cell_kind_type kind;
    logic [`EVT_INFO_W-1:0] cell_ptr;
    logic [`EVT_INFO_W-1:0] lcd_ptr;
  } cell_evt_type;
  // Routing class flags
  typedef struct packed {
    logic error;
    logic count;
    logic tx_comp;
    logic tx_dma;
    logic rx_dma;
    logic abr;
    logic pool;
  } route_type;
  // Finished entry
  typedef struct packed {
    logic valid;
    logic [`EVT_WORD_W-1:0] word;
    route_type route;
    logic [2:0] queue;
  } evt_out_type;
endpackage

//--- tb_receive_event_encoder.sv
// Self-checking bench for the receive event encoder: every packet, cell and raw event code.
// Assumes the encoder package and module are compiled first; the bench drives all ports.
`timescale 1ns/1ps
module tb_receive_event_encoder;
  import rx_event_pkg::*;
  logic sys_clk_in = 1'b0;                 // 125 MHz core clock
  logic rst_in = 1'b1;                     // Synchronous reset, active high
  pkt_evt_type pkt_evt_in = '0;            // Reassembly report
  cell_evt_type cell_evt_in = '0;          // Cell report
  raw_evt_type raw_evt_in = '0;            // Generic report
  logic bad_frame_en_in = 1'b0;            // Bad-frame reception switch
  logic thresh_up_in = 1'b0;               // Threshold crossing direction
  logic [2:0] abr_queue_in = 3'h5;         // Queue for ABR codes
  logic [2:0] class_queue_in = 3'h2;       // Queue for all other codes
  logic queue_ready_in = 1'b1;             // Queue unit ready
  logic pkt_ack_out;
  logic cell_ack_out;
  logic raw_ack_out;
  evt_out_type evt_out;
  int errors = 0;                          // Mismatch count
  int n_checks = 0;                        // Comparison count
  // Pointers with low bits set, so a missing clear shows up in the word
  logic [25:0] pkt_ptr = 26'h25a5a7f;
  logic [25:0] lcd_ptr = 26'h1c3c3ff;
  logic [25:0] clr_mask = 26'h3ffffc0;
  wire logic [2:0] acks = {raw_ack_out, cell_ack_out, pkt_ack_out};

  rx_event_encoder rx_event_encoder_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .pkt_evt_in(pkt_evt_in), .bad_frame_en_in(bad_frame_en_in),
    .cell_evt_in(cell_evt_in), .raw_evt_in(raw_evt_in), .thresh_up_in(thresh_up_in),
    .abr_queue_in(abr_queue_in), .class_queue_in(class_queue_in), .queue_ready_in(queue_ready_in),
    .pkt_ack_out(pkt_ack_out), .cell_ack_out(cell_ack_out), .raw_ack_out(raw_ack_out), .evt_out(evt_out)
  );

  // Clock: half period 4 ns
  always #4 sys_clk_in = ~sys_clk_in;

  // Routing class flags {error,count,tx_comp,tx_dma,rx_dma,abr,pool} expected for a code
  function automatic logic [6:0] route_of(input logic [5:0] c);
    case (c)
      6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0f, 6'h10, 6'h11, 6'h12,
      6'h13, 6'h16, 6'h38, 6'h39, 6'h3a, 6'h3c: route_of = 7'h40;
      6'h18, 6'h19, 6'h1a, 6'h1b, 6'h3d: route_of = 7'h20;
      6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h23: route_of = 7'h10;
      6'h24, 6'h26, 6'h28: route_of = 7'h08;
      6'h25, 6'h27, 6'h3b: route_of = 7'h04;
      6'h29: route_of = 7'h0c;
      6'h2c, 6'h2d, 6'h2e, 6'h2f: route_of = 7'h02;
      6'h3e: route_of = 7'h01;
      default: route_of = 7'h00;
    endcase
  endfunction

  // Code and pointer choice per report kind; choice 0 own pointer, 1 descriptor, 2 bad-frame pick
  function automatic logic [7:0] src_exp(input int sel, input logic [3:0] k);
    logic [7:0] p[14] = '{8'h00, 8'h0e, 8'h82, 8'h8f, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'hb8,
                          8'hb9, 8'hba, 8'hbc, 8'h01};
    logic [7:0] c[13] = '{8'h08, 8'h09, 8'h8a, 8'h0b, 8'h0c, 8'h0d, 8'h50, 8'h51, 8'h52, 8'h53,
                          8'h54, 8'h55, 8'h56};
    src_exp = (sel == 0) ? p[k] : c[k];
  endfunction

  // One comparison; a mismatch is printed at once
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Judge the entry that stands on the output
  task automatic check_out(input logic [5:0] code, input logic [25:0] info);
    logic [2:0] q;
    q = (code >= 6'h2c && code <= 6'h2f) ? abr_queue_in : class_queue_in;
    cmp("valid", 32'h1, 32'(evt_out.valid));
    cmp("word", {code, info}, evt_out.word);
    cmp("route", 32'(route_of(code)), 32'(evt_out.route));
    cmp("queue", 32'(q), 32'(evt_out.queue));
  endtask

  // Wait for one source's ack, bounded, and sample just after the edge
  task automatic wait_ack(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end while (acks[sel] !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("[ERR] ack expected 1 seen %b", acks[sel]);
    end
  endtask

  // Packet (sel 0) or cell (sel 1) report of kind k, with the bad-frame switch at bfe
  task automatic run_src(input int sel, input int k, input logic bfe);
    logic [7:0] e;
    logic [25:0] info;
    e = src_exp(sel, k[3:0]);
    info = (e[7:6] == 2'd0 || (e[7:6] == 2'd2 && bfe)) ? (pkt_ptr & clr_mask) : (lcd_ptr & clr_mask);
    @(posedge sys_clk_in);
    bad_frame_en_in <= bfe;
    if (sel == 0) pkt_evt_in <= '{valid: 1'b1, kind: pkt_kind_type'(k[3:0]), pkt_ptr: pkt_ptr, lcd_ptr: lcd_ptr};
    else cell_evt_in <= '{valid: 1'b1, kind: cell_kind_type'(k[3:0]), cell_ptr: pkt_ptr, lcd_ptr: lcd_ptr};
    wait_ack(sel);
    check_out(e[5:0], info);
    // Drop the request; the edge right after the ack ignores it anyway
    @(posedge sys_clk_in);
    pkt_evt_in.valid <= 1'b0;
    cell_evt_in.valid <= 1'b0;
  endtask

  // Raw report; threshold codes get the direction in info bit six, all else passes as given
  task automatic run_raw(input logic [5:0] code, input logic up);
    logic [25:0] src;
    logic [25:0] info;
    src = up ? 26'h15a5a95 : 26'h15a5ad5;
    info = src;
    if (code == 6'h1e || code == 6'h1f) info[6] = up;
    @(posedge sys_clk_in);
    thresh_up_in <= up;
    raw_evt_in <= '{valid: 1'b1, code: code, info: src};
    wait_ack(2);
    check_out(code, info);
    @(posedge sys_clk_in);
    raw_evt_in.valid <= 1'b0;
  endtask

  // All three sources at once behind a stalled queue: packet first, entry held, then cell, then raw
  task automatic stall_priority();
    logic [31:0] held;
    @(posedge sys_clk_in);
    queue_ready_in <= 1'b0;
    pkt_evt_in <= '{valid: 1'b1, kind: pkt_good, pkt_ptr: pkt_ptr, lcd_ptr: lcd_ptr};
    cell_evt_in <= '{valid: 1'b1, kind: cell_user, cell_ptr: lcd_ptr, lcd_ptr: lcd_ptr};
    raw_evt_in <= '{valid: 1'b1, code: 6'h20, info: 26'h0abcdef};
    wait_ack(0);
    cmp("acks", 32'h1, 32'(acks));
    check_out(6'h00, pkt_ptr & clr_mask);
    held = evt_out.word;
    repeat (4) begin
      @(posedge sys_clk_in);
      pkt_evt_in.valid <= 1'b0;
      #1;
      cmp("stalled word", held, evt_out.word);
      cmp("stalled acks", 32'h0, 32'(acks));
    end
    @(posedge sys_clk_in);
    queue_ready_in <= 1'b1;
    wait_ack(1);
    check_out(6'h08, lcd_ptr & clr_mask);
    // Raw is taken on the very next edge while the cell word drains
    @(posedge sys_clk_in);
    cell_evt_in.valid <= 1'b0;
    #1;
    cmp("raw acks", 32'h4, 32'(acks));
    check_out(6'h20, 26'h0abcdef);
    @(posedge sys_clk_in);
    raw_evt_in.valid <= 1'b0;
    #1;
    cmp("drained valid", 32'h0, 32'(evt_out.valid));
    cmp("drained acks", 32'h0, 32'(acks));
  endtask

  // Closing: counts, then the verdict
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog: the whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    errors++;
    $display("[ERR] watchdog expected done seen running");
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    cmp("reset valid", 32'h0, 32'(evt_out.valid));
    cmp("reset acks", 32'h0, 32'(acks));
    // Every packet kind under both bad-frame settings
    for (int k = 0; k < 14; k++) begin
      run_src(0, k, 1'b0);
      run_src(0, k, 1'b1);
    end
    // Every cell kind under both bad-frame settings
    for (int k = 0; k < 13; k++) begin
      run_src(1, k, 1'b0);
      run_src(1, k, 1'b1);
    end
    // Raw codes from counters upward, skipping reserved and packet-only codes
    for (int c = 6'h18; c < 64; c++) begin
      if (!(c inside {6'h1c, 6'h1d, 6'h2a, 6'h2b, 6'h38, 6'h39, 6'h3a, 6'h3c}))
        run_raw(c[5:0], 1'b0);
    end
    run_raw(6'h1e, 1'b1);
    run_raw(6'h1f, 1'b1);
    stall_priority();
    give_verdict();
  end
endmodule
